// File: hdl/rcf_pkg.sv
// ==========================================================================
// Reset-cause flag constants
package rcf_pkg;

    // ======================================================================
    // Register port geometry
    localparam int          ADDR_W = 8;
    localparam int          DATA_W = 32;

    // ======================================================================
    // Register offsets (byte addresses, one aligned word each)
    localparam logic [7:0]  OFS_CAUSE_CTRL = 8'h00;
    localparam logic [7:0]  OFS_IRQ_STATUS = 8'h04;
    localparam logic [7:0]  OFS_IRQ_MASK   = 8'h08;

    // ======================================================================
    // Cause indices into the flag bank
    localparam int          CAUSE_N     = 6;
    localparam int          IDX_SOFT    = 0;
    localparam int          IDX_WDOG    = 1;
    localparam int          IDX_POWER   = 2;
    localparam int          IDX_PIN     = 3;
    localparam int          IDX_HANG    = 4;
    localparam int          IDX_VOLT    = 5;

    // ======================================================================
    // Field positions in the cause/control register
    localparam int          BIT_SOFT    = 28;
    localparam int          BIT_WDOG    = 29;
    localparam int          BIT_POWER   = 27;
    localparam int          BIT_PIN     = 26;
    localparam int          BIT_CLEAR   = 24;
    localparam int          BIT_HANG    = 23;
    localparam int          BIT_VOLT    = 22;
    localparam int          BIT_HANG_EN = 7;
    localparam int          BIT_VOLT_EN = 6;

    // ======================================================================
    // Reset values
    localparam logic [5:0]  FLAGS_RST   = 6'h04;
    localparam logic        HANG_EN_RST = 1'b0;
    localparam logic        VOLT_EN_RST = 1'b0;
    localparam logic [5:0]  IRQ_RST     = 6'h00;
    localparam logic [31:0] WORD_ZERO   = 32'h00000000;

    typedef logic [CAUSE_N-1:0] rcf_cause_t;

    // Spread a cause vector onto its register bit positions
    function automatic logic [31:0] rcf_place(input rcf_cause_t v);
        logic [31:0] w;
        w = WORD_ZERO;
        w[BIT_SOFT]  = v[IDX_SOFT];
        w[BIT_WDOG]  = v[IDX_WDOG];
        w[BIT_POWER] = v[IDX_POWER];
        w[BIT_PIN]   = v[IDX_PIN];
        w[BIT_HANG]  = v[IDX_HANG];
        w[BIT_VOLT]  = v[IDX_VOLT];
        return w;
    endfunction

    // Gather register bit positions back into a cause vector
    function automatic rcf_cause_t rcf_gather(input logic [31:0] w);
        rcf_cause_t v;
        v           = '0;
        v[IDX_SOFT]  = w[BIT_SOFT];
        v[IDX_WDOG]  = w[BIT_WDOG];
        v[IDX_POWER] = w[BIT_POWER];
        v[IDX_PIN]   = w[BIT_PIN];
        v[IDX_HANG]  = w[BIT_HANG];
        v[IDX_VOLT]  = w[BIT_VOLT];
        return v;
    endfunction

endpackage

// File: hdl/rcf_flag_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Link between register logic and the flag bank
interface rcf_flag_if;
    import rcf_pkg::*;
    rcf_cause_t set_req;     // Per-cause set, one bit per index
    logic       clear_all;   // Software removal of all flags
    logic       power_clear; // Power reset: wipe before setting
    rcf_cause_t flags;       // Stored flags

    modport bank (
        input  set_req,
        input  clear_all,
        input  power_clear,
        output flags
    );
    modport ctrl (
        output set_req,
        output clear_all,
        output power_clear,
        input  flags
    );
endinterface
`default_nettype wire

// File: hdl/rcf_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Sticky reset-cause flag storage
module rcf_flag_bank (
    // Clock and reset
    input wire logic    clk,
    input wire logic    rst_n,
    // Flag link
    rcf_flag_if.bank    fl
);
    import rcf_pkg::*;

    logic [CAUSE_N-1:0] flag_q;

    // One flop per cause, set wins over any clear so events are not lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= FLAGS_RST;
        end else begin
            for (int i = 0; i < CAUSE_N; i++) begin
                if (fl.set_req[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (fl.clear_all || fl.power_clear) begin
                    flag_q[i] <= 1'b0;
                end
            end
        end
    end

    assign fl.flags = flag_q;

endmodule
`default_nettype wire

// File: hdl/rcf_reset_cause.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Reset-cause flags with control enables and interrupt
module rcf_reset_cause (
    // Clock and power reset
    input  wire logic                   CORE_CLK,
    input  wire logic                   RST_N,
    // Register port
    input  wire logic [rcf_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [rcf_pkg::DATA_W-1:0] WDATA,
    input  wire logic                   WR,
    input  wire logic                   RD,
    output logic      [rcf_pkg::DATA_W-1:0] RDATA,
    // Reset source events
    input  wire logic                   SOFT_RESET_EVT,
    input  wire logic                   WATCHDOG_RESET_EVT,
    input  wire logic                   POWER_UP_DOWN_DETECTOR_EVT,
    input  wire logic                   EXTERNAL_RESET_PIN_EVT,
    input  wire logic                   CORE_HANG_EVT,
    input  wire logic                   PROGRAMMABLE_VOLTAGE_DETECTOR_EVT,
    // Reset requests to the sequencer
    output logic                        CORE_HANG_RESET_REQ,
    output logic                        VOLTAGE_RESET_REQ,
    // Interrupt
    output logic                        IRQ
);
    import rcf_pkg::*;

    // ======================================================================
    // Internal signals
    rcf_flag_if         flag_link ();

    logic               core_hang_reset_enable;
    logic               voltage_detect_reset_enable;
    rcf_cause_t         irq_status;
    rcf_cause_t         irq_mask;
    rcf_cause_t         cause_set;
    rcf_cause_t         next_irq_status;
    logic               hit_cause;
    logic               hit_irq_st;
    logic               hit_irq_mk;
    logic               clear_cause_flags;
    logic               hang_reset;
    logic               volt_reset;
    logic [31:0]        cause_word;
    logic [31:0]        next_rdata;

    // ======================================================================
    // Address decode
    assign hit_cause  = (ADDR == OFS_CAUSE_CTRL);
    assign hit_irq_st = (ADDR == OFS_IRQ_STATUS);
    assign hit_irq_mk = (ADDR == OFS_IRQ_MASK);

    // ======================================================================
    // Reset generation gated by enables
    // Lockup only becomes a reset, and a flag, while enabled
    assign hang_reset = CORE_HANG_EVT && core_hang_reset_enable;
    // Voltage detector only becomes a reset while enabled
    assign volt_reset = PROGRAMMABLE_VOLTAGE_DETECTOR_EVT
                        && voltage_detect_reset_enable;

    // Registered reset requests, one cycle after the enabled event
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            CORE_HANG_RESET_REQ <= 1'b0;
            VOLTAGE_RESET_REQ   <= 1'b0;
        end else begin
            CORE_HANG_RESET_REQ <= hang_reset;
            VOLTAGE_RESET_REQ   <= volt_reset;
        end
    end

    // ======================================================================
    // Cause collection
    // Every active source raises its own bit, hang and voltage only while enabled; several may coexist
    always_comb begin
        cause_set            = '0;
        cause_set[IDX_SOFT]  = SOFT_RESET_EVT;
        cause_set[IDX_WDOG]  = WATCHDOG_RESET_EVT;
        cause_set[IDX_POWER] = POWER_UP_DOWN_DETECTOR_EVT;
        cause_set[IDX_PIN]   = EXTERNAL_RESET_PIN_EVT;
        cause_set[IDX_HANG]  = hang_reset;
        cause_set[IDX_VOLT]  = volt_reset;
    end

    // Software removal: a one in the clear bit, a zero does nothing
    assign clear_cause_flags = WR && hit_cause && WDATA[BIT_CLEAR];

    // Drive the flag bank
    assign flag_link.set_req     = cause_set;
    assign flag_link.clear_all   = clear_cause_flags;
    // A power-down detection is a power reset and wipes older causes
    assign flag_link.power_clear = POWER_UP_DOWN_DETECTOR_EVT;

    // ======================================================================
    // Flag storage
    rcf_flag_bank u_bank (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .fl    (flag_link.bank)
    );

    // ======================================================================
    // Control enables, written with the cause register
    // Reserved bits are ignored on write; software keeps them at reset value
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            core_hang_reset_enable      <= HANG_EN_RST;
            voltage_detect_reset_enable <= VOLT_EN_RST;
        end else if (WR && hit_cause) begin
            core_hang_reset_enable      <= WDATA[BIT_HANG_EN];
            voltage_detect_reset_enable <= WDATA[BIT_VOLT_EN];
        end
    end

    // ======================================================================
    // Interrupt status, sticky, write one to clear, set wins
    always_comb begin
        next_irq_status = irq_status;
        if (WR && hit_irq_st) begin
            next_irq_status = irq_status & ~rcf_gather(WDATA);
        end
        next_irq_status = next_irq_status | cause_set;
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_status <= IRQ_RST;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // Interrupt mask, same layout as the status
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_mask <= IRQ_RST;
        end else if (WR && hit_irq_mk) begin
            irq_mask <= rcf_gather(WDATA);
        end
    end

    // Level interrupt while any unmasked status bit is set
    assign IRQ = |(irq_status & irq_mask);

    // ======================================================================
    // Read path
    // Cause word: flags, enables; clear bit and reserved bits read zero
    always_comb begin
        cause_word              = rcf_place(flag_link.flags);
        cause_word[BIT_HANG_EN] = core_hang_reset_enable;
        cause_word[BIT_VOLT_EN] = voltage_detect_reset_enable;
    end

    // Select read data, unmapped offsets read zero
    always_comb begin
        next_rdata = WORD_ZERO;
        if (RD) begin
            if (hit_cause) begin
                next_rdata = cause_word;
            end else if (hit_irq_st) begin
                next_rdata = rcf_place(irq_status);
            end else if (hit_irq_mk) begin
                next_rdata = rcf_place(irq_mask);
            end
        end
    end

    // Read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= WORD_ZERO;
        end else begin
            RDATA <= next_rdata;
        end
    end

endmodule
`default_nettype wire

// File: tb/rcf_reset_cause_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Port-level checks of the reset-cause flags
module rcf_reset_cause_sva (
    // Clock and reset
    input wire logic                       CORE_CLK,
    input wire logic                       RST_N,
    // Register port
    input wire logic [rcf_pkg::ADDR_W-1:0] ADDR,
    input wire logic                       WR,
    input wire logic                       RD,
    input wire logic [rcf_pkg::DATA_W-1:0] RDATA,
    // Events and requests
    input wire logic                       SOFT_RESET_EVT,
    input wire logic                       WATCHDOG_RESET_EVT,
    input wire logic                       POWER_UP_DOWN_DETECTOR_EVT,
    input wire logic                       EXTERNAL_RESET_PIN_EVT,
    input wire logic                       CORE_HANG_EVT,
    input wire logic                       PROGRAMMABLE_VOLTAGE_DETECTOR_EVT,
    input wire logic                       CORE_HANG_RESET_REQ,
    input wire logic                       VOLTAGE_RESET_REQ
);
    import rcf_pkg::*;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // Cause read, and a cycle with nothing that could wipe flags
    logic rd0;
    logic quiet;
    assign rd0   = RD && (ADDR == OFS_CAUSE_CTRL);
    assign quiet = !WR && !POWER_UP_DOWN_DETECTOR_EVT;

    soft_flag_a: assert property (SOFT_RESET_EVT ##1 quiet ##1 rd0 |=> RDATA[BIT_SOFT])
        else $error("soft cause flag missing");
    wdog_flag_a: assert property (
        WATCHDOG_RESET_EVT ##1 quiet ##1 rd0 |=> RDATA[BIT_WDOG])
        else $error("watchdog cause flag missing");
    power_flag_a: assert property (
        POWER_UP_DOWN_DETECTOR_EVT ##1 quiet ##1 rd0 |=> RDATA[BIT_POWER])
        else $error("power cause flag missing");
    pin_flag_a: assert property (
        EXTERNAL_RESET_PIN_EVT ##1 quiet ##1 rd0 |=> RDATA[BIT_PIN])
        else $error("pin cause flag missing");
    hang_flag_a: assert property ((CORE_HANG_RESET_REQ && quiet) ##1 rd0 |=> RDATA[BIT_HANG])
        else $error("hang cause flag missing");
    volt_flag_a: assert property ((VOLTAGE_RESET_REQ && quiet) ##1 rd0 |=> RDATA[BIT_VOLT])
        else $error("voltage cause flag missing");
    flags_sticky_a: assert property ((rd0 && !POWER_UP_DOWN_DETECTOR_EVT) ##1 rd0 |=>
        (RDATA & $past(RDATA)) == $past(RDATA)) else $error("cause flag dropped");
    clear_reads_a: assert property (!RDATA[BIT_CLEAR])
        else $error("clear bit reads one");
    hang_req_a: assert property (CORE_HANG_RESET_REQ |-> $past(CORE_HANG_EVT))
        else $error("hang request without event");
    volt_req_a: assert property (
        VOLTAGE_RESET_REQ |-> $past(PROGRAMMABLE_VOLTAGE_DETECTOR_EVT))
        else $error("voltage request without event");
endmodule
`default_nettype wire

// File: tb/tb_rcf_reset_cause.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Register-level bench for the reset-cause flags
module tb_rcf_reset_cause;
    import rcf_pkg::*;
    localparam logic [31:0] P = 32'h08000000, S = 32'h10000000, W = 32'h20000000;
    localparam logic [31:0] N = 32'h04000000, H = 32'h00800000, V = 32'h00400000;
    localparam logic [31:0] EN = 32'h000000C0, CLR = 32'h01000000;
    localparam logic [31:0] EW [4] = '{S, W, P, N};
    logic              core_clk;
    logic              rst_n;
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [5:0]        evt;
    logic              hreq;
    logic              vreq;
    logic              irq;
    logic [1:0]        reqs;
    int                num_errors;
    int                checked;

    rcf_reset_cause DUT (
        .CORE_CLK(core_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .SOFT_RESET_EVT(evt[IDX_SOFT]), .WATCHDOG_RESET_EVT(evt[IDX_WDOG]),
        .POWER_UP_DOWN_DETECTOR_EVT(evt[IDX_POWER]), .EXTERNAL_RESET_PIN_EVT(evt[IDX_PIN]),
        .CORE_HANG_EVT(evt[IDX_HANG]), .PROGRAMMABLE_VOLTAGE_DETECTOR_EVT(evt[IDX_VOLT]),
        .CORE_HANG_RESET_REQ(hreq), .VOLTAGE_RESET_REQ(vreq), .IRQ(irq));

    // Clock at 25 MHz
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Compare one result
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    // Verdict and end of run
    task automatic final_report;
        $display("errors %0d, checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Power reset held for 16 cycles
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
    endtask

    // One-cycle register write
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask

    // One-cycle read, data checked in the following cycle
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        chk(n, e, rdata);
    endtask

    // One-cycle event pulse; requests captured the cycle after
    task automatic ev(input logic [5:0] v);
        @(posedge core_clk);
        evt <= v;
        @(posedge core_clk);
        evt <= 6'h00;
        #1;
        reqs = {hreq, vreq};
    endtask

    // Hang guard
    initial begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        final_report;
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = '0;
        evt = 6'h00;
        num_errors = 0;
        checked = 0;
        do_reset;
        rc(OFS_CAUSE_CTRL, P, "cause after reset");
        rc(OFS_IRQ_STATUS, 32'h0, "status after reset");
        rc(OFS_IRQ_MASK, 32'h0, "mask after reset");
        wreg(OFS_CAUSE_CTRL, CLR);
        rc(OFS_CAUSE_CTRL, 32'h0, "cause after clear");
        for (int i = 0; i < 4; i++) begin
            wreg(OFS_CAUSE_CTRL, CLR);
            ev(6'h01 << i);
            rc(OFS_CAUSE_CTRL, EW[i], "single cause");
        end
        ev(6'h03);
        wreg(OFS_CAUSE_CTRL, 32'h0);
        // Back-to-back reads of the held flags
        @(posedge core_clk);
        addr <= OFS_CAUSE_CTRL;
        rd <= 1'b1;
        @(posedge core_clk);
        #1;
        chk("joint causes", S | W | N, rdata);
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        chk("causes reread", S | W | N, rdata);
        ev(6'h04);
        rc(OFS_CAUSE_CTRL, P, "after power event");
        wreg(OFS_CAUSE_CTRL, CLR);
        ev(6'h30);
        chk("requests disabled", 32'h0, {30'h0, reqs});
        rc(OFS_CAUSE_CTRL, 32'h0, "disabled sources");
        wreg(OFS_CAUSE_CTRL, EN);
        ev(6'h10);
        chk("hang request", 32'h2, {30'h0, reqs});
        rc(OFS_CAUSE_CTRL, EN | H, "hang cause");
        ev(6'h20);
        chk("voltage request", 32'h1, {30'h0, reqs});
        rc(OFS_CAUSE_CTRL, EN | H | V, "voltage cause");
        wreg(8'h0C, 32'hFFFFFFFF);
        rc(8'h0C, 32'h0, "unmapped read");
        rc(OFS_CAUSE_CTRL, EN | H | V, "cause after unmapped");
        wreg(OFS_IRQ_STATUS, 32'hFFFFFFFF);
        wreg(OFS_IRQ_MASK, S);
        ev(6'h02);
        chk("masked irq", 32'h0, {31'h0, irq});
        ev(6'h01);
        chk("unmasked irq", 32'h1, {31'h0, irq});
        wreg(OFS_IRQ_STATUS, S);
        #1;
        chk("irq after clear", 32'h0, {31'h0, irq});
        rc(OFS_IRQ_STATUS, W, "irq status");
        do_reset;
        rc(OFS_CAUSE_CTRL, P, "cause after second reset");
        final_report;
    end
endmodule

bind rcf_reset_cause rcf_reset_cause_sva CHK (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SOFT_RESET_EVT(SOFT_RESET_EVT), .WATCHDOG_RESET_EVT(WATCHDOG_RESET_EVT),
    .POWER_UP_DOWN_DETECTOR_EVT(POWER_UP_DOWN_DETECTOR_EVT),
    .EXTERNAL_RESET_PIN_EVT(EXTERNAL_RESET_PIN_EVT), .CORE_HANG_EVT(CORE_HANG_EVT),
    .PROGRAMMABLE_VOLTAGE_DETECTOR_EVT(PROGRAMMABLE_VOLTAGE_DETECTOR_EVT),
    .CORE_HANG_RESET_REQ(CORE_HANG_RESET_REQ), .VOLTAGE_RESET_REQ(VOLTAGE_RESET_REQ));
`default_nettype wire
